// File: inc/pt_pkg.sv
// Shared constants and types of the pattern tester.
// Assumes a 20 MHz reference clock and one bit per bit-clock step.
package pt_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_HZ = 20000000; // Reference clock rate
  localparam int SECOND_S = 1; // Injection and timer unit, seconds
  localparam int SECOND_CYCLES = SECOND_S * REF_CLK_HZ; // Cycles per second

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00; // Control word
  localparam logic [4:0] OFS_PHASE = 5'h04; // Sampling phase
  localparam logic [4:0] OFS_INJ = 5'h08; // Injected error rate
  localparam logic [4:0] OFS_ERRS = 5'h0c; // Accumulated errors
  localparam logic [4:0] OFS_BITS = 5'h10; // Compared bits
  localparam logic [4:0] OFS_TIME = 5'h14; // Elapsed seconds
  localparam logic [4:0] OFS_STAT = 5'h18; // Live status

  // ---------------------------------------------------------------
  // Control and status field positions
  // ---------------------------------------------------------------
  localparam int CTRL_PATH_LO = 0; // Data path, two bits
  localparam int CTRL_INV = 2; // Output inversion
  localparam int CTRL_CHK_ON = 3; // Checker on, else training
  localparam int CTRL_SYNTH = 4; // Internal synthesiser select
  localparam int CTRL_REMOTE = 5; // Remote bus control
  localparam int CTRL_NOIN = 6; // No-input sense
  localparam int CTRL_PAT_LO = 8; // Pattern length, two bits
  localparam int CTRL_MARK_LO = 16; // Mark density, eight bits
  localparam int STAT_ERR = 0; // Live error indicator
  localparam int STAT_MARK = 1; // Pattern marker level
  localparam int STAT_ADDR_LO = 8; // Bus address, five bits

  // ---------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------
  localparam logic [7:0] MARK_HALF = 8'h80; // Density one half
  localparam logic [8:0] PHASE_MAX = 9'h166; // 358 degrees
  localparam logic [8:0] PHASE_RST = 9'h000; // 0 degrees
  localparam logic [3:0] INJ_OFF = 4'h0; // No injection
  localparam logic [3:0] INJ_MAX = 4'h8; // Code 8 is 1E7 per second
  localparam logic [4:0] BUS_ADDR_DEFAULT = 5'h19; // Address 25
  localparam logic [4:0] MARK_PERIODS = 5'h1f; // 32 periods, minus one
  localparam logic [30:0] LFSR_SEED = 31'h7fffffff; // All ones

  typedef enum logic [1:0] {PATH_OFF, PATH_ON, PATH_THRU} pt_path_type;
  typedef enum logic [1:0] {PAT_7, PAT_15, PAT_23, PAT_31} pt_pat_type;
  typedef enum logic {BUS_IDLE, BUS_ACK} pt_bus_type;

  // Next feedback bit of the selected maximal-length sequence
  function automatic logic ptFeedback(logic [30:0] s, pt_pat_type sel);
    logic fb;
    fb = 1'b0;
    case (sel)
      PAT_7: fb = s[6] ^ s[5];
      PAT_15: fb = s[14] ^ s[13];
      PAT_23: fb = s[22] ^ s[17];
      default: fb = s[30] ^ s[27];
    endcase
    return fb;
  endfunction

  // Mask of the stages that belong to the selected sequence
  function automatic logic [30:0] ptMask(pt_pat_type sel);
    logic [30:0] m;
    m = 31'h7fffffff;
    case (sel)
      PAT_7: m = 31'h0000007f;
      PAT_15: m = 31'h00007fff;
      PAT_23: m = 31'h007fffff;
      default: m = 31'h7fffffff;
    endcase
    return m;
  endfunction

endpackage

// File: inc/pt_pat_if.sv
// Pattern signals between the top and its generator and checker.
// Assumes all three sit on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface pt_pat_if;
  import pt_pkg::*;
  pt_pat_type patSel; // Selected sequence length
  logic txStep; // Generator advances one bit
  logic txBit; // Current generator bit
  logic periodEnd; // Generator back at seed
  logic rxStep; // Checker compares one bit
  logic rxBit; // Received bit
  logic training; // Checker re-synchronises
  logic cmpPulse; // One bit was compared
  logic errPulse; // Compared bit mismatched
  modport ctl (output patSel, txStep, rxStep, rxBit, training,
    input txBit, periodEnd, cmpPulse, errPulse);
  modport gen (input patSel, txStep, output txBit, periodEnd);
  modport chk (input patSel, rxStep, rxBit, training,
    output cmpPulse, errPulse);
endinterface
`default_nettype wire

// File: verilog/pt_pattern_gen.sv
// Maximal-length pattern generator.
// Assumes txStep is a one-cycle strobe from the top.
`timescale 1ns/1ps
`default_nettype none
module pt_pattern_gen
  import pt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  pt_pat_if.gen pif
);

  logic [30:0] lfsr_r; // Shift register state
  logic [30:0] lfsr_nxt; // State after one step

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  // Shift in the feedback bit of the selected sequence
  always_comb begin
    lfsr_nxt = {lfsr_r[29:0], ptFeedback(lfsr_r, pif.patSel)};
  end

  // Advance on each step
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lfsr_r <= LFSR_SEED;
    end else if (pif.txStep) begin
      lfsr_r <= lfsr_nxt;
    end
  end

  // Output bit is the newest stage
  assign pif.txBit = lfsr_r[0];

  // Period completes when the active stages return to the seed
  assign pif.periodEnd = pif.txStep &&
    ((lfsr_nxt & ptMask(pif.patSel)) == ptMask(pif.patSel));

endmodule
`default_nettype wire

// File: verilog/pt_error_checker.sv
// Self-synchronising error checker.
// Assumes rxStep is a one-cycle strobe and rxBit is synchronised.
`timescale 1ns/1ps
`default_nettype none
module pt_error_checker
  import pt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  pt_pat_if.chk pif
);

  logic [30:0] ref_r; // Reference sequence state
  logic expect_w; // Predicted received bit
  logic cmp_r; // Compare strobe
  logic err_r; // Mismatch strobe

  assign expect_w = ptFeedback(ref_r, pif.patSel);

  // ---------------------------------------------------------------
  // Reference
  // ---------------------------------------------------------------
  // Training loads received bits, running mode free-runs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_r <= LFSR_SEED;
    end else if (pif.rxStep) begin
      if (pif.training) begin
        ref_r <= {ref_r[29:0], pif.rxBit};
      end else begin
        ref_r <= {ref_r[29:0], expect_w};
      end
    end
  end

  // Mismatch shows in training and running alike
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmp_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      cmp_r <= pif.rxStep;
      err_r <= pif.rxStep && (pif.rxBit != expect_w);
    end
  end

  assign pif.cmpPulse = cmp_r;
  assign pif.errPulse = err_r;

endmodule
`default_nettype wire

// File: verilog/pt_pattern_tester.sv
// Pattern tester top: bus slave, clocking, data path and counters.
// Assumes Avalon-MM master on ref_clk; serial and clock pins are async.
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module pt_pattern_tester
  import pt_pkg::*;
#(
  parameter int CYCLES_PER_SECOND = SECOND_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic txClockIn,
  input wire logic rxClockIn,
  output logic txClockOut,
  output logic rxClockOut,
  input wire logic serialIn,
  output logic serialOutP,
  output logic serialOutN,
  output logic passthroughPortP,
  output logic passthroughPortN,
  output logic patternMarkerOut,
  output logic errorLight,
  input wire logic [4:0] addrSwitch
);

  pt_pat_if pif ();

  // ---------------------------------------------------------------
  // Settings
  // ---------------------------------------------------------------
  pt_path_type path_r; // Data path mode
  logic invert_r; // Output inversion
  logic chkOn_r; // Checker on, else training
  logic synth_r; // Internal synthesiser selected
  logic remote_r; // Remote bus control
  logic noInput_r; // No-input sense
  pt_pat_type pat_r; // Pattern length
  logic [8:0] phase_r; // Sampling phase, degrees
  logic [3:0] inj_r; // Injection rate code

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  pt_bus_type bus_r; // Slave state
  pt_bus_type bus_nxt; // Next slave state
  logic busReq; // Read or write pending
  logic wrEn; // Write takes effect
  logic [31:0] rdData_r; // Read data held for the answer
  logic [31:0] rdMux; // Selected read value
  logic [31:0] ctrlWord; // Control word as read

  assign busReq = avs_read || avs_write;
  assign avs_waitrequest = busReq && (bus_r != BUS_ACK);
  assign wrEn = avs_write && (bus_r == BUS_ACK);
  assign avs_readdata = rdData_r;

  // One wait cycle, then the answer
  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      BUS_IDLE: begin
        if (busReq) begin
          bus_nxt = BUS_ACK;
        end
      end
      BUS_ACK: bus_nxt = BUS_IDLE;
      default: bus_nxt = BUS_IDLE;
    endcase
  end

  // Slave state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_r <= BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Counters and status
  // ---------------------------------------------------------------
  logic [31:0] errs_r; // Accumulated errors
  logic [31:0] bits_r; // Compared bits
  logic [31:0] secs_r; // Elapsed seconds
  logic [31:0] secCnt_r; // Cycles into the current second
  logic [4:0] busAddr_r; // Remote bus address
  logic marker_r; // Pattern marker level
  logic chkOnDly_r; // Checker-on, one cycle late
  logic session; // New session starts

  // Control word assembly
  always_comb begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[CTRL_PATH_LO +: 2] = path_r;
    ctrlWord[CTRL_INV] = invert_r;
    ctrlWord[CTRL_CHK_ON] = chkOn_r;
    ctrlWord[CTRL_SYNTH] = synth_r;
    ctrlWord[CTRL_REMOTE] = remote_r;
    ctrlWord[CTRL_NOIN] = noInput_r;
    ctrlWord[CTRL_PAT_LO +: 2] = pat_r;
    ctrlWord[CTRL_MARK_LO +: 8] = MARK_HALF;
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (avs_address)
      OFS_CTRL: rdMux = ctrlWord;
      OFS_PHASE: rdMux = {23'h000000, phase_r};
      OFS_INJ: rdMux = {28'h0000000, inj_r};
      OFS_ERRS: rdMux = errs_r;
      OFS_BITS: rdMux = bits_r;
      OFS_TIME: rdMux = secs_r;
      OFS_STAT: begin
        rdMux[STAT_ERR] = errorLight;
        rdMux[STAT_MARK] = marker_r;
        rdMux[STAT_ADDR_LO +: 5] = busAddr_r;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData_r <= 32'h0000_0000;
    end else if (avs_read && bus_r == BUS_IDLE) begin
      rdData_r <= rdMux;
    end
  end

  // Control register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      path_r <= PATH_OFF;
      invert_r <= 1'b0;
      chkOn_r <= 1'b0;
      synth_r <= 1'b1;
      remote_r <= 1'b0;
      noInput_r <= 1'b0;
      pat_r <= PAT_31;
    end else if (wrEn && avs_address == OFS_CTRL) begin
      if (avs_writedata[CTRL_PATH_LO +: 2] == 2'h3) begin
        path_r <= PATH_OFF;
      end else begin
        path_r <= pt_path_type'(avs_writedata[CTRL_PATH_LO +: 2]);
      end
      invert_r <= avs_writedata[CTRL_INV];
      chkOn_r <= avs_writedata[CTRL_CHK_ON];
      synth_r <= avs_writedata[CTRL_SYNTH];
      remote_r <= avs_writedata[CTRL_REMOTE];
      noInput_r <= avs_writedata[CTRL_NOIN];
      pat_r <= pt_pat_type'(avs_writedata[CTRL_PAT_LO +: 2]);
    end
  end

  // Phase and injection writes, phase clamped to one unit interval
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_r <= PHASE_RST;
      inj_r <= INJ_OFF;
    end else if (wrEn && avs_address == OFS_PHASE) begin
      phase_r <= (avs_writedata[8:0] > PHASE_MAX) ? PHASE_MAX : avs_writedata[8:0];
    end else if (wrEn && avs_address == OFS_INJ) begin
      inj_r <= (avs_writedata[3:0] > INJ_MAX) ? INJ_MAX : avs_writedata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Clock pins
  // ---------------------------------------------------------------
  logic [2:0] txCkSync_r; // Two-stage sync plus edge history
  logic [2:0] rxCkSync_r; // Two-stage sync plus edge history
  logic [1:0] rxSync_r; // Serial input synchroniser
  logic [4:0] addrSync1_r; // Switch sync, first stage
  logic [4:0] addrSync2_r; // Switch sync, second stage
  logic txStep; // Generator bit step
  logic rxStep; // Checker bit step

  // Synchronise pins from outside the clock domain
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txCkSync_r <= 3'h0;
      rxCkSync_r <= 3'h0;
      rxSync_r <= 2'h0;
      // Preload the shipped address so busAddr_r never dips to zero
      addrSync1_r <= BUS_ADDR_DEFAULT;
      addrSync2_r <= BUS_ADDR_DEFAULT;
    end else begin
      txCkSync_r <= {txCkSync_r[1:0], txClockIn};
      rxCkSync_r <= {rxCkSync_r[1:0], rxClockIn};
      rxSync_r <= {rxSync_r[0], serialIn};
      addrSync1_r <= addrSwitch;
      addrSync2_r <= addrSync1_r;
    end
  end

  // Internal synthesiser clocks out, half the reference rate
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txClockOut <= 1'b0;
      rxClockOut <= 1'b0;
    end else begin
      txClockOut <= ~txClockOut;
      rxClockOut <= ~rxClockOut;
    end
  end

  // Internal source steps every cycle; external on input rising edges
  assign txStep = synth_r || (txCkSync_r[1] && !txCkSync_r[2]);
  assign rxStep = synth_r || (rxCkSync_r[1] && !rxCkSync_r[2]);

  // Address follows the switch once out of reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busAddr_r <= BUS_ADDR_DEFAULT;
    end else begin
      busAddr_r <= addrSync2_r;
    end
  end

  // ---------------------------------------------------------------
  // Generator, checker and data path
  // ---------------------------------------------------------------
  logic [4:0] markCnt_r; // Completed periods
  logic [31:0] injCnt_r; // Cycles toward next injection
  logic [31:0] injInterval; // Cycles between injections
  logic injPend_r; // Injection waiting for a bit
  logic injWrap; // Injection interval elapsed
  logic genOn; // Generator drives the output
  logic txOut; // Outgoing bit

  // Cycles between errors for a rate code of 10^(code-1) per second
  function automatic logic [31:0] ptInterval(logic [3:0] code);
    int iv;
    iv = CYCLES_PER_SECOND;
    for (int k = 1; k < 8; k++) begin
      if (code > 4'(k)) begin
        iv = iv / 10;
      end
    end
    return 32'(iv);
  endfunction

  assign injInterval = ptInterval(inj_r);
  assign injWrap = (inj_r != INJ_OFF) && (injCnt_r >= injInterval - 32'h1);
  assign genOn = (path_r != PATH_OFF);

  assign pif.patSel = pat_r;
  assign pif.txStep = txStep && genOn;
  assign pif.rxStep = rxStep && (path_r != PATH_THRU);
  assign pif.rxBit = rxSync_r[1];
  assign pif.training = !chkOn_r;

  pt_pattern_gen u_gen (
    .ref_clk(ref_clk),
    .rst(rst),
    .pif(pif)
  );

  pt_error_checker u_chk (
    .ref_clk(ref_clk),
    .rst(rst),
    .pif(pif)
  );

  // Injection timer; a new interval wins over consuming the last
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      injCnt_r <= 32'h0;
      injPend_r <= 1'b0;
    end else begin
      injCnt_r <= injWrap || inj_r == INJ_OFF ? 32'h0 : injCnt_r + 32'h1;
      if (injWrap) begin
        injPend_r <= 1'b1;
      end else if (pif.txStep) begin
        injPend_r <= 1'b0;
      end
    end
  end

  // Outgoing bit with inversion and one flipped bit per injection
  assign txOut = pif.txBit ^ invert_r ^ injPend_r;

  // Main output pair and pass-through pair
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serialOutP <= 1'b0;
      serialOutN <= 1'b1;
      passthroughPortP <= 1'b0;
      passthroughPortN <= 1'b1;
    end else begin
      if (pif.txStep) begin
        serialOutP <= txOut;
        serialOutN <= ~txOut;
      end else if (!genOn) begin
        serialOutP <= 1'b0;
        serialOutN <= 1'b1;
      end
      passthroughPortP <= (path_r == PATH_THRU) && rxSync_r[1];
      passthroughPortN <= !((path_r == PATH_THRU) && rxSync_r[1]);
    end
  end

  // Marker toggles after every 32 complete periods
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      markCnt_r <= 5'h00;
      marker_r <= 1'b0;
    end else if (pif.periodEnd) begin
      markCnt_r <= markCnt_r + 5'h01;
      if (markCnt_r == MARK_PERIODS) begin
        marker_r <= ~marker_r;
      end
    end
  end

  assign patternMarkerOut = marker_r;

  // Live indicator follows each compared mismatch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      errorLight <= 1'b0;
    end else begin
      errorLight <= pif.errPulse;
    end
  end

  // ---------------------------------------------------------------
  // Session counters
  // ---------------------------------------------------------------
  assign session = chkOn_r && !chkOnDly_r;

  // Error and bit counts clear at session start, held while off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chkOnDly_r <= 1'b0;
      errs_r <= 32'h0;
      bits_r <= 32'h0;
    end else begin
      chkOnDly_r <= chkOn_r;
      if (session) begin
        errs_r <= 32'h0;
        bits_r <= 32'h0;
      end else if (chkOn_r && pif.cmpPulse) begin
        bits_r <= bits_r + 32'h1;
        if (pif.errPulse && errs_r != 32'hffffffff) begin
          errs_r <= errs_r + 32'h1;
        end
      end
    end
  end

  // Elapsed seconds advance only while the checker is on
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      secCnt_r <= 32'h0;
      secs_r <= 32'h0;
    end else if (session) begin
      secCnt_r <= 32'h0;
      secs_r <= 32'h0;
    end else if (chkOn_r) begin
      if (secCnt_r >= 32'(CYCLES_PER_SECOND - 1)) begin
        secCnt_r <= 32'h0;
        secs_r <= secs_r + 32'h1;
      end else begin
        secCnt_r <= secCnt_r + 32'h1;
      end
    end
  end

endmodule
`default_nettype wire

// File: verification/pt_loop_model.sv
// Loopback partner: the device under test returns the serial stream.
// Assumes the tester's clock outputs are cabled back to its clock inputs.
`timescale 1ns/1ps
`default_nettype none
module pt_loop_model (
  input wire logic ref_clk,
  input wire logic txClockOut,
  input wire logic rxClockOut,
  input wire logic serialOutP,
  output logic txClockIn,
  output logic rxClockIn,
  output logic serialIn
);
  // Each clock output feeds its own input
  assign txClockIn = txClockOut;
  assign rxClockIn = rxClockOut;
  // One cycle of cable delay
  always_ff @(posedge ref_clk) begin
    serialIn <= serialOutP;
  end
endmodule
`default_nettype wire

// File: verification/pt_pattern_tester_sva.sv
// Checker on the pattern tester top ports.
// Assumes one clock, ref_clk, and synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module pt_pattern_tester_sva
  import pt_pkg::*;
#(
  parameter int CYCLES_PER_SECOND = SECOND_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic txClockOut,
  input wire logic rxClockOut,
  input wire logic serialOutP,
  input wire logic serialOutN,
  input wire logic passthroughPortP,
  input wire logic passthroughPortN,
  input wire logic patternMarkerOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic prevMark_r; // Marker level one cycle ago
  logic [15:0] markCnt_r; // Cycles since the last marker toggle
  // Marker interval counter
  always_ff @(posedge ref_clk) begin
    prevMark_r <= patternMarkerOut;
    if (rst || patternMarkerOut != prevMark_r) begin
      markCnt_r <= 16'h0000;
    end else if (markCnt_r != 16'hffff) begin
      markCnt_r <= markCnt_r + 16'h0001;
    end
  end
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_clk;
    $rose(txClockOut) && $rose(rxClockOut) ##1 $fell(txClockOut) && $fell(rxClockOut);
  endsequence
  property p_bus_ack; s_req |=> !avs_waitrequest; endproperty
  property p_bus_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  property p_rd_hold; avs_read && !avs_waitrequest |=> $stable(avs_readdata); endproperty
  property p_clk_run; $fell(rst) |-> ##[0:3] s_clk; endproperty
  property p_rst_out;
    $fell(rst) |-> (!serialOutP && serialOutN && !passthroughPortP && !patternMarkerOut) [*2];
  endproperty
  property p_out_pair; serialOutN == !serialOutP; endproperty
  property p_thru_pair; passthroughPortN == !passthroughPortP; endproperty
  property p_marker_slow; (patternMarkerOut != prevMark_r) |-> markCnt_r >= 16'd4063; endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("no answer after request");
  a_bus_idle: assert property (p_bus_idle) else $error("waitrequest while idle");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_clk_run: assert property (p_clk_run) else $error("internal clock idle");
  a_rst_out: assert property (p_rst_out) else $error("outputs active after reset");
  a_out_pair: assert property (p_out_pair) else $error("main pair not opposite");
  a_thru_pair: assert property (p_thru_pair) else $error("thru pair not opposite");
  a_marker_slow: assert property (p_marker_slow) else $error("marker toggled early");
endmodule
bind pt_pattern_tester pt_pattern_tester_sva #(.CYCLES_PER_SECOND(CYCLES_PER_SECOND)) pt_pattern_tester_sva_inst (.*);
`default_nettype wire

// File: verification/pt_pattern_tester_tb.sv
// Self-checking bench for the pattern tester in loopback.
// Assumes package, interface, design, partner and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module pt_pattern_tester_tb;
  import pt_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0] avs_address = 5'h00, addrSwitch = BUS_ADDR_DEFAULT;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata, q, e0, b0, ctrlModel = 32'h00800310;
  logic avs_waitrequest, txClockIn, rxClockIn, txClockOut, rxClockOut, serialIn, errorLight;
  logic serialOutP, serialOutN, passthroughPortP, passthroughPortN, patternMarkerOut;
  int num_errors = 0, checks_done = 0, n, v, t0, lightCnt = 0, tgA, tgB;
  always #25 ref_clk = ~ref_clk;
  pt_pattern_tester #(.CYCLES_PER_SECOND(200)) pt_pattern_tester_inst (.*);
  pt_loop_model pt_loop_model_inst (.*);
  // Count indicator pulses at the falling edge, where errorLight is settled
  always @(negedge ref_clk) if (errorLight === 1'b1) lightCnt++;
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpRange(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  // Avalon access: hold until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // No local limit: only the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w && a == OFS_CTRL) ctrlModel = (d & 32'h0000037f) | 32'h00800000;
  endtask
  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h00000000);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic waitMark;
    logic m;
    m = patternMarkerOut;
    n = 0;
    while (patternMarkerOut === m && n < 9000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    num_errors++;
    stop_test();
  end
  initial begin
    v = $urandom(32'h206546cf);
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_CTRL); cmpWord(q, ctrlModel);
    rd(OFS_PHASE); cmpWord(q, 32'h00000000);
    rd(OFS_INJ); cmpWord(q, 32'h00000000);
    rd(OFS_ERRS); cmpWord(q, 32'h00000000);
    rd(OFS_STAT); cmpWord(q & 32'h00001f00, 32'h00001900);
    rd(5'h1c); cmpWord(q, 32'h00000000);
    $display("test defaults done");
    wr(OFS_CTRL, 32'h00000011);
    waitMark();
    waitMark(); cmpWord(n, 32'd4064);
    $display("test marker done");
    t0 = lightCnt;
    wr(OFS_CTRL, 32'h00000019);
    repeat (300) @(posedge ref_clk);
    rd(OFS_ERRS); cmpWord(q, 32'h00000000);
    rd(OFS_BITS); cmpRange(q, 280, 330);
    cmpWord(lightCnt - t0, 0);
    rd(OFS_CTRL); cmpWord(q, ctrlModel);
    $display("test clean done");
    wr(OFS_CTRL, 32'h0000001d);
    repeat (20) @(posedge ref_clk);
    rd(OFS_ERRS); e0 = q;
    rd(OFS_BITS); b0 = q;
    repeat (100) @(posedge ref_clk);
    rd(OFS_ERRS); e0 = q - e0;
    rd(OFS_BITS); cmpWord(e0, q - b0);
    cmpRange(e0, 90, 120);
    wr(OFS_CTRL, 32'h00000015);
    rd(OFS_ERRS); e0 = q;
    rd(OFS_TIME); b0 = q;
    t0 = lightCnt;
    repeat (400) @(posedge ref_clk);
    cmpRange(lightCnt - t0, 1, 400);
    rd(OFS_ERRS); cmpWord(q, e0);
    rd(OFS_TIME); cmpWord(q, b0);
    $display("test invert done");
    wr(OFS_CTRL, 32'h00000012);
    wr(OFS_CTRL, 32'h0000001a);
    t0 = lightCnt;
    tgA = 0;
    tgB = 0;
    repeat (64) begin
      @(posedge ref_clk);
      if (serialOutP !== serialOutN) tgA = tgA + (serialOutP ^ serialIn);
      if (passthroughPortP === 1'b1) tgB++;
    end
    cmpRange(tgA, 1, 64);
    cmpRange(tgB, 1, 63);
    rd(OFS_ERRS); cmpWord(q, 32'h00000000);
    rd(OFS_BITS); cmpWord(q, 32'h00000000);
    cmpWord(lightCnt - t0, 0);
    $display("test passthrough done");
    wr(OFS_CTRL, 32'h00000001);
    repeat (100) @(posedge ref_clk);
    wr(OFS_CTRL, 32'h00000009);
    repeat (200) @(posedge ref_clk);
    rd(OFS_ERRS); cmpWord(q, 32'h00000000);
    rd(OFS_BITS); cmpRange(q, 90, 110);
    $display("test external clock done");
    wr(OFS_CTRL, 32'h00000011);
    repeat (100) @(posedge ref_clk);
    wr(OFS_INJ, 32'h00000001);
    wr(OFS_CTRL, 32'h00000019);
    t0 = lightCnt;
    repeat (1000) @(posedge ref_clk);
    cmpRange(lightCnt - t0, 4, 6);
    rd(OFS_ERRS); cmpRange(q, 4, 6);
    rd(OFS_TIME); cmpRange(q, 4, 5);
    v = $urandom_range(15, 0);
    wr(OFS_INJ, v);
    rd(OFS_INJ); cmpWord(q, (v > 8) ? 8 : v);
    $display("test inject done");
    repeat (4) begin
      v = $urandom_range(511, 0);
      wr(OFS_PHASE, v);
      rd(OFS_PHASE); cmpWord(q, (v > 358) ? 358 : v);
    end
    addrSwitch <= 5'($urandom);
    repeat (4) @(posedge ref_clk);
    rd(OFS_STAT); cmpWord(32'(q[12:8]), 32'(addrSwitch));
    $display("test settings done");
    stop_test();
  end
endmodule
`default_nettype wire
